/* design/spcs_cfg.svh */
`ifndef SPCS_CFG_SVH
`define SPCS_CFG_SVH

// special-function register addresses
`define SPCS_CTRL_ADDR   8'hf8
`define SPCS_DATA_ADDR   8'hf9

// control and status field positions
`define SPCS_DONE_BIT    7
`define SPCS_WRITE_COLLISION_FLAG_BIT    6
`define SPCS_MODE_FAULT_FLAG_BIT    5
`define SPCS_OVR_BIT     4
`define SPCS_MODE_HI     3
`define SPCS_MODE_LO     2
`define SPCS_TRANSMIT_BUFFER_EMPTY_BIT   1
`define SPCS_EN_BIT      0

// reset values
`define SPCS_MODE_RST    2'h1
`define SPCS_TRANSMIT_BUFFER_EMPTY_RST   1'b1
`define SPCS_PINS_RST    4'h1

// slave-select mode encodings
`define SPCS_MODE_3W     2'h0
`define SPCS_MODE_4W_IN  2'h1

// timing and sizes
`define SPCS_HALF_DIV    8'h04
`define SPCS_LAST_BIT    4'h7
`define SPCS_FIFO_DEPTH  4
`define SPCS_DATA_W      8

`endif

/* design/spcs_pkg.sv */
package spcs_pkg;

    typedef enum logic [1:0]
    {
        SPCS_IDLE = 2'h0,
        SPCS_MSTR = 2'h1,
        SPCS_SLV  = 2'h2
    } spcs_fsm_t;

    typedef struct packed
    {
        logic sck;
        logic mosi;
        logic miso;
        logic ss;
    } spcs_pins_t;

    typedef struct packed
    {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } spcs_sfr_t;

    typedef struct packed
    {
        spcs_fsm_t  fsm;
        logic       done;
        logic       write_collision_flag;
        logic       mode_fault_flag;
        logic       ovr;
        logic [1:0] mode;
        logic       transmit_buffer_empty;
        logic       en;
        logic [7:0] txbuf;
        logic [7:0] sh;
        logic       samp;
        logic [3:0] cnt;
        logic       sck_q;
        logic [7:0] div;
        logic       sck_prev;
        logic [7:0] rdata;
        logic       irq;
        spcs_pins_t po;
        spcs_pins_t poe;
    } spcs_st_t;

endpackage : spcs_pkg

/* design/spcs_sync.sv */
module spcs_sync #(
    parameter int              WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] d_out
);

    typedef struct packed
    {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } spcs_sync_st_t;

    spcs_sync_st_t q;
    spcs_sync_st_t d;

    // two stages; only the second is read outside
    always_comb
    begin
        d    = q;
        d.s1 = d_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '{s1: RST_VAL, s2: RST_VAL};
        else
            q <= d;
    end

    assign d_out = q.s2;

endmodule : spcs_sync

/* design/spcs_fifo.sv */
module spcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
        logic [WIDTH-1:0]            dout;
    } spcs_fifo_st_t;

    spcs_fifo_st_t q;
    spcs_fifo_st_t d;

    logic [AW:0] fill;

    assign fill      = q.wp - q.rp;
    assign in_ready  = (fill != (AW+1)'(DEPTH));
    assign out_valid = (q.wp != q.rp);
    assign out_data  = q.dout;

    // head word is read into a register from the next pointer state
    always_comb
    begin
        d = q;
        if (in_valid && in_ready)
        begin
            d.mem[q.wp[AW-1:0]] = in_data;
            d.wp                = q.wp + (AW+1)'(1);
        end
        if (out_valid && out_ready)
            d.rp = q.rp + (AW+1)'(1);
        d.dout = d.mem[d.rp[AW-1:0]];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

endmodule : spcs_fifo

/* design/spcs_top.sv */
// Operation
// RULE1: transfer end sets done; only software clears
// RULE2: done flag raises interrupt while interrupts enabled
// RULE3: data write while busy sets collision flag
// RULE4: select low, master, mode 01 sets fault
// RULE5: slave last bit into full buffer: overrun
// RULE6: mode 00: three-wire, select not routed
// RULE7: mode 01 default: select is an input
// RULE8: mode 1x: select driven with low bit
// RULE9: data write clears transmit empty flag; a write while busy is refused and leaves the flag set
// RULE10: buffer moved to shifter sets transmit empty
// RULE11: enable bit gates the whole serial interface; mode fault detection and data register writes are not gated by it
`include "spcs_cfg.svh"

module spcs_top #(
    parameter logic [7:0] HALF_DIV   = `SPCS_HALF_DIV,
    parameter int         FIFO_DEPTH = `SPCS_FIFO_DEPTH
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire spcs_pkg::spcs_sfr_t   sfr,
    output logic       [7:0]           sfr_rdata,
    input  wire logic                  master_enable,
    input  wire logic                  irq_enable,
    output logic                       spi_irq,
    input  wire spcs_pkg::spcs_pins_t  pin_i,
    output spcs_pkg::spcs_pins_t       pin_o,
    output spcs_pkg::spcs_pins_t       pin_oe
);

    // the data pins reach the shifter two cycles late; a half period
    // shorter than three cycles would sample the bit before the shift
    localparam logic [7:0] HALF_EFF = (HALF_DIV < 8'h03) ? 8'h03 : HALF_DIV;

    localparam spcs_pkg::spcs_st_t RST_ST = '{
        fsm:   spcs_pkg::SPCS_IDLE,
        mode:  `SPCS_MODE_RST,
        transmit_buffer_empty: `SPCS_TRANSMIT_BUFFER_EMPTY_RST,
        default: '0
    };

    spcs_pkg::spcs_st_t   q;
    spcs_pkg::spcs_st_t   d;
    spcs_pkg::spcs_pins_t syn;
    logic [3:0]           syn_v;

    logic                 rx_valid;
    logic                 rx_ready;
    logic [7:0]           rx_byte;
    logic                 rx_pop;
    logic                 rx_avail;
    logic [7:0]           rx_head;

    logic                 selected;
    logic                 master_on;
    logic                 busy;
    logic                 tick;
    logic                 rise;
    logic                 fall;
    logic                 din;
    logic                 last;

    // register address decode
    function automatic logic hit(
        input spcs_pkg::spcs_sfr_t r,
        input logic [7:0]          a
    );
        hit = (r.addr == a);
    endfunction : hit

    // four-wire input mode is the only one that reads the select pin
    function automatic logic select_is_input(
        input logic [1:0] m
    );
        select_is_input = (m == `SPCS_MODE_4W_IN);
    endfunction : select_is_input

    // a status flag survives a control write only when written with one
    function automatic logic keep_flag(
        input logic f,
        input logic w
    );
        keep_flag = f && w;
    endfunction : keep_flag

    // a byte is moving: master frame, or slave between first and last bit
    function automatic logic xfer_busy(
        input spcs_pkg::spcs_st_t s
    );
        xfer_busy = (s.fsm == spcs_pkg::SPCS_MSTR)
                    || ((s.fsm == spcs_pkg::SPCS_SLV) && (s.cnt != 4'h0));
    endfunction : xfer_busy

    // control and status word as software sees it
    function automatic logic [7:0] ctrl_word(
        input spcs_pkg::spcs_st_t s
    );
        ctrl_word = {s.done, s.write_collision_flag, s.mode_fault_flag, s.ovr, s.mode, s.transmit_buffer_empty, s.en};
    endfunction : ctrl_word

    // the link clock and data-out pins belong to an enabled master
    function automatic logic master_drives(
        input logic e,
        input logic m
    );
        master_drives = e && m;
    endfunction : master_drives

    // pins from outside pass two flops first
    spcs_sync #(
        .WIDTH   (4),
        .RST_VAL (`SPCS_PINS_RST)
    ) u_sync (
        .clk   (clk),
        .rst   (rst),
        .d_in  (pin_i),
        .d_out (syn_v)
    );

    assign syn = spcs_pkg::spcs_pins_t'(syn_v);

    // received bytes wait here until software reads them
    spcs_fifo #(
        .WIDTH (`SPCS_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_byte),
        .out_valid (rx_avail),
        .out_ready (rx_pop),
        .out_data  (rx_head)
    );

    assign rx_pop = sfr.rd && hit(sfr, `SPCS_DATA_ADDR) && rx_avail;

    always_comb
    begin
        d        = q;
        rise     = 1'b0;
        fall     = 1'b0;
        last     = 1'b0;
        rx_valid = 1'b0;
        rx_byte  = {q.sh[6:0], 1'b0};

        // select is only looked at in the four-wire input mode
        if (select_is_input(q.mode))
            selected = !syn.ss; // RULE7
        else
            selected = 1'b1; // RULE6

        master_on = master_drives(q.en, master_enable); // RULE11
        busy      = xfer_busy(q);
        tick      = (q.div == (HALF_EFF - 8'h01));
        din       = (q.fsm == spcs_pkg::SPCS_MSTR) ? syn.miso : syn.mosi;
        d.sck_prev = syn.sck;

        // software write to control: flags only cleared by a zero
        if (sfr.wr && hit(sfr, `SPCS_CTRL_ADDR))
        begin
            d.done = keep_flag(q.done, sfr.wdata[`SPCS_DONE_BIT]); // RULE1
            d.write_collision_flag = keep_flag(q.write_collision_flag, sfr.wdata[`SPCS_WRITE_COLLISION_FLAG_BIT]);
            d.mode_fault_flag = keep_flag(q.mode_fault_flag, sfr.wdata[`SPCS_MODE_FAULT_FLAG_BIT]);
            d.ovr  = keep_flag(q.ovr, sfr.wdata[`SPCS_OVR_BIT]);
            d.mode = sfr.wdata[`SPCS_MODE_HI:`SPCS_MODE_LO];
            d.en   = sfr.wdata[`SPCS_EN_BIT];
        end

        // transfer sequencing
        case (q.fsm)
            spcs_pkg::SPCS_IDLE:
            begin
                d.sck_q = 1'b0;
                d.div   = 8'h00;
                d.cnt   = 4'h0;
                if (master_on && !q.transmit_buffer_empty && rx_ready)
                begin
                    d.fsm   = spcs_pkg::SPCS_MSTR;
                    d.sh    = q.txbuf;
                    d.transmit_buffer_empty = 1'b1; // RULE10
                end
                else if (q.en && !master_enable && selected)
                begin
                    d.fsm = spcs_pkg::SPCS_SLV;
                end
            end
            spcs_pkg::SPCS_MSTR:
            begin
                if (!master_on)
                begin
                    d.fsm   = spcs_pkg::SPCS_IDLE; // RULE11
                    d.sck_q = 1'b0;
                    d.cnt   = 4'h0;
                end
                else
                begin
                    d.div = tick ? 8'h00 : q.div + 8'h01;
                    if (tick)
                    begin
                        d.sck_q = !q.sck_q;
                        rise    = !q.sck_q;
                        fall    = q.sck_q;
                        if (q.sck_q && (q.cnt == 4'h0))
                            d.fsm = spcs_pkg::SPCS_IDLE;
                    end
                end
            end
            spcs_pkg::SPCS_SLV:
            begin
                if (!q.en || master_enable || !selected)
                begin
                    d.fsm = spcs_pkg::SPCS_IDLE; // RULE11
                    d.cnt = 4'h0;
                end
                else
                begin
                    rise = syn.sck && !q.sck_prev;
                    fall = !syn.sck && q.sck_prev;
                    if ((q.cnt == 4'h0) && !q.transmit_buffer_empty)
                    begin
                        d.sh    = q.txbuf;
                        d.transmit_buffer_empty = 1'b1; // RULE10
                    end
                end
            end
            default:
            begin
                d.fsm = spcs_pkg::SPCS_IDLE;
            end
        endcase

        // shared shift engine: sample on rising, shift on falling
        if (rise)
        begin
            d.samp = din;
            d.cnt  = q.cnt + 4'h1;
            if (q.cnt == `SPCS_LAST_BIT)
            begin
                last     = 1'b1;
                d.cnt    = 4'h0;
                rx_byte  = {q.sh[6:0], din};
                rx_valid = 1'b1;
                d.done   = 1'b1; // RULE1
            end
        end
        if (fall && (q.cnt != 4'h0))
            d.sh = {q.sh[6:0], q.samp};

        // a slave cannot stall the remote master
        if (last && !rx_ready && (q.fsm == spcs_pkg::SPCS_SLV))
            d.ovr = 1'b1; // RULE5

        // data register write: refused while a byte is moving
        if (sfr.wr && hit(sfr, `SPCS_DATA_ADDR))
        begin
            if (busy)
                d.write_collision_flag = 1'b1; // RULE3
            else
            begin
                d.txbuf = sfr.wdata;
                d.transmit_buffer_empty = 1'b0; // RULE9
            end
        end

        // master collision on the select input
        if (select_is_input(q.mode) && !syn.ss && master_enable)
            d.mode_fault_flag = 1'b1; // RULE4

        // register read answer
        if (sfr.rd)
        begin
            if (hit(sfr, `SPCS_CTRL_ADDR))
                d.rdata = ctrl_word(q);
            else if (hit(sfr, `SPCS_DATA_ADDR))
                d.rdata = rx_head;
            else
                d.rdata = 8'h00;
        end

        // interrupt request from any pending event
        d.irq = irq_enable && (d.done || d.write_collision_flag || d.mode_fault_flag || d.ovr); // RULE2

        // pin drivers
        d.po.sck    = d.sck_q;
        d.po.mosi   = d.sh[7];
        d.po.miso   = d.sh[7];
        d.po.ss     = d.mode[0]; // RULE8
        d.poe.sck   = master_drives(d.en, master_enable); // RULE11
        d.poe.mosi  = master_drives(d.en, master_enable);
        d.poe.miso  = (d.fsm == spcs_pkg::SPCS_SLV);
        d.poe.ss    = d.en && d.mode[1]; // RULE8
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            q <= RST_ST;
        else
            q <= d;
    end

    assign sfr_rdata = q.rdata;
    assign spi_irq   = q.irq;
    assign pin_o     = q.po;
    assign pin_oe    = q.poe;

endmodule : spcs_top

/* sim/spcs_chk.sv */
module spcs_chk (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire spcs_pkg::spcs_sfr_t  sfr,
    input wire logic [7:0]           sfr_rdata,
    input wire logic                 master_enable,
    input wire logic                 irq_enable,
    input wire logic                 spi_irq,
    input wire spcs_pkg::spcs_pins_t pin_i,
    input wire spcs_pkg::spcs_pins_t pin_o,
    input wire spcs_pkg::spcs_pins_t pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] ctl_q;
    logic       cwr;
    logic       dwr;
    assign cwr = sfr.wr && sfr.addr == 8'hf8;
    assign dwr = sfr.wr && sfr.addr == 8'hf9;
    // shadow of the writable control bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctl_q <= 4'h4;
        else if (cwr)
            ctl_q <= sfr.wdata[3:0];
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_IRQ_GATE: assert property (!irq_enable |=> !spi_irq)
        else $error("irq while disabled");
    AST_STICKY: assert property (spi_irq && irq_enable && !cwr && !$past(cwr) |=> spi_irq)
        else $error("flag dropped by hardware");
    AST_FAULT: assert property ((ctl_q[3:2] == 2'h1 && master_enable && irq_enable && !pin_i.ss)[*4]
        |-> ##[0:4] spi_irq)
        else $error("no mode fault");
    AST_WRITE_COLLISION_FLAG: assert property (dwr && pin_oe.sck && pin_o.sck && irq_enable ##1 irq_enable
        |=> spi_irq)
        else $error("no write collision");
    AST_SS_IN: assert property ($stable(ctl_q) && !ctl_q[3] |-> !pin_oe.ss)
        else $error("select driven");
    AST_SS_OUT: assert property ($stable(ctl_q) && ctl_q[3] && ctl_q[0]
        |-> pin_oe.ss && pin_o.ss == ctl_q[2])
        else $error("select output wrong");
    AST_EN: assert property ($stable(ctl_q) && !ctl_q[0] |-> pin_oe == 4'h0)
        else $error("pins driven while disabled");
    AST_READBACK: assert property (sfr.rd && sfr.addr == 8'hf8 && !cwr
        |=> sfr_rdata[3:2] == $past(ctl_q[3:2]) && sfr_rdata[0] == $past(ctl_q[0]))
        else $error("control readback wrong");
endmodule : spcs_chk

bind spcs_top spcs_chk chk (.clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .master_enable(master_enable), .irq_enable(irq_enable), .spi_irq(spi_irq),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));

/* sim/spcs_peer.sv */
module spcs_peer (
    input  wire spcs_pkg::spcs_pins_t pin_o,
    input  wire spcs_pkg::spcs_pins_t pin_oe,
    output spcs_pkg::spcs_pins_t      pin_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // loopback shifter: each frame returns the byte of the frame before
    logic [7:0] sr  = 8'h3c;
    logic       b   = 1'b0;
    logic       sck = 1'b0;
    logic       ss  = 1'b1;
    always_comb
    begin
        pin_i.sck  = pin_oe.sck ? pin_o.sck : sck;
        pin_i.mosi = pin_oe.mosi ? pin_o.mosi : sr[7] ^ ss;
        pin_i.miso = pin_oe.miso ? pin_o.miso : sr[7];
        pin_i.ss   = pin_oe.ss ? pin_o.ss : ss;
    end
    always @(posedge pin_i.sck)
        b = pin_oe.sck ? pin_i.mosi : pin_i.miso;
    always @(negedge pin_i.sck)
        if ($time > 0)
            sr = {sr[6:0], b};
    // one byte as master, link clock still outside the frame
    task frame;
        #7;
        ss = 1'b0;
        #100;
        repeat (8)
        begin
            sck = 1'b1;
            #100;
            sck = 1'b0;
            #100;
        end
        ss = 1'b1;
    endtask : frame
endmodule : spcs_peer

/* sim/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                 clk           = 1'b0;
    logic                 rst           = 1'b1;
    spcs_pkg::spcs_sfr_t  sfr           = '0;
    logic                 master_enable = 1'b0;
    logic                 irq_enable    = 1'b0;
    logic [7:0]           sfr_rdata;
    logic                 spi_irq;
    spcs_pkg::spcs_pins_t pin_i;
    spcs_pkg::spcs_pins_t pin_o;
    spcs_pkg::spcs_pins_t pin_oe;
    int                   failures = 0;
    int                   compares = 0;
    int                   seed     = 66866;
    logic [7:0]           prev     = 8'h3c;
    logic [7:0]           d;
    logic [7:0]           v;
    logic [7:0]           q[$];
    always #12.5 clk = ~clk;
    spcs_top #(.HALF_DIV(8'h04)) dut (.clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .master_enable(master_enable), .irq_enable(irq_enable), .spi_irq(spi_irq),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
    spcs_peer peer (.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
    task chk(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] w);
        @(negedge clk);
        sfr = '{a, 1'b1, 1'b0, w};
        @(negedge clk);
        sfr.wr = 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] r);
        @(negedge clk);
        sfr = '{a, 1'b0, 1'b1, 8'h00};
        @(negedge clk);
        sfr.rd = 1'b0;
        @(negedge clk);
        r = sfr_rdata;
    endtask : rd
    task rdq;
        rd(8'hf9, v);
        chk(q.pop_front(), v);
    endtask : rdq
    task poll;
        v = 8'h00;
        for (int i = 0; i < 100 && v[7] !== 1'b1; i++)
            rd(8'hf8, v);
    endtask : poll
    task conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    initial
    begin
        #500000;
        failures++;
        conclude();
    end
    initial
    begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd(8'hf8, v);
        chk(8'h06, v);
        wr(8'hf9, 8'h5a);
        rd(8'hf8, v);
        chk(8'h04, v);
        chk(8'h00, {4'h0, pin_oe});
        for (int m = 0; m < 4; m++)
        begin
            wr(8'hf8, 8'(m * 4 + 1));
            repeat (3) @(negedge clk);
            chk(8'(m / 2), {7'h0, pin_oe.ss});
            if (m > 1)
                chk(8'(m % 2), {7'h0, pin_o.ss});
        end
        master_enable = 1'b1;
        irq_enable = 1'b1;
        wr(8'hf8, 8'h05);
        for (int i = 0; i < 5; i++)
        begin
            d = 8'($random(seed));
            wr(8'hf9, d);
            q.push_back(prev);
            prev = d;
            if (i == 2)
            begin
                wait (pin_o.sck === 1'b1);
                wr(8'hf9, ~d);
            end
            if (i == 4)
            begin
                repeat (80) @(negedge clk);
                rd(8'hf8, v);
                chk(8'h05, v);
                while (q.size() > 1)
                    rdq();
            end
            poll();
            chk(i == 2 ? 8'hc7 : 8'h87, v);
            chk(8'h01, {7'h0, spi_irq});
            wr(8'hf8, 8'h05);
        end
        rdq();
        peer.ss = 1'b0;
        repeat (8) @(negedge clk);
        rd(8'hf8, v);
        chk(8'h27, v);
        peer.ss = 1'b1;
        repeat (4) @(negedge clk);
        wr(8'hf8, 8'h05);
        master_enable = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            d = 8'($random(seed));
            wr(8'hf9, d);
            repeat (4) @(negedge clk);
            peer.frame();
            if (i < 4)
                q.push_back(prev);
            prev = d;
            poll();
            chk(i == 4 ? 8'h97 : 8'h87, v);
            wr(8'hf8, 8'h05);
        end
        while (q.size() > 0)
            rdq();
        conclude();
    end
endmodule : tb
